// File: pkg/dbg_pkg.sv
/*
 * constants and carrier types for the dual byte gpio port block:
 * register offsets, reset values, address window limits, bit positions.
 * assumes a byte wide processor access with a 12 bit address.
 */
package dbg_pkg;

    localparam int             DBG_WIDTH       = 8;
    localparam int             DBG_ADDR_W      = 12;

    // special register area and data buffer area decode limits
    localparam logic [11:0]    SRA_FIRST       = 12'h000;
    localparam logic [11:0]    SRA_LAST        = 12'h03F;
    localparam logic [11:0]    DBA_FIRST       = 12'hF80;
    localparam logic [11:0]    DBA_LAST        = 12'hFFF;

    // register offsets
    localparam logic [11:0]    PORT0_DATA_OFS  = 12'h000;
    localparam logic [11:0]    PORT1_DATA_OFS  = 12'h001;
    localparam logic [11:0]    PORT0_DIR_OFS   = 12'h008;
    localparam logic [11:0]    PORT1_DIR_OFS   = 12'h009;

    // values after reset
    localparam logic [7:0]     PORT0_DATA_RST  = 8'h00;
    localparam logic [7:0]     PORT1_DATA_RST  = 8'h00;
    localparam logic [7:0]     PORT0_DIR_RST   = 8'h00;
    localparam logic [7:0]     PORT1_DIR_RST   = 8'h00;

    // second port alternate function bit positions
    localparam int             P1_IRQ0_BIT     = 0;
    localparam int             P1_IRQ1_BIT     = 1;
    localparam int             P1_IRQ2_BIT     = 2;
    localparam int             P1_TIMER1_BIT   = 2;
    localparam int             P1_DIV_BIT      = 3;
    localparam int             P1_PULSE_BIT    = 4;
    localparam int             P1_TIMER2_BIT   = 5;

    // processor access phases
    typedef enum logic [1:0] {
        DBG_IDLE,
        DBG_READ_SAMPLE,
        DBG_WRITE_UPDATE
    } dbg_phase_type;

    // one port's pad signals
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dbg_pad_type;

    // one port's register pair
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
    } dbg_port_type;

endpackage : dbg_pkg

// File: hdl/dbg_port_slice.sv
/*
 * one 8 bit port: output latch, direction register, pad drive and
 * read mux. assumes the parent decodes the address and gives write
 * strobes in the write update state.
 */
`timescale 1ns/1ns
module dbg_port_slice
    import dbg_pkg::*;
#(
    parameter logic [7:0] DATA_RST = 8'h00,
    parameter logic [7:0] DIR_RST  = 8'h00
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // register writes
    input  wire logic        data_we,
    input  wire logic        dir_we,
    input  wire logic [7:0]  wdata,
    // pad side
    input  wire logic [7:0]  pin_in,
    input  wire logic        drive_ok,
    output dbg_pad_type      pad,
    // register read views
    output logic      [7:0]  data_view,
    output logic      [7:0]  dir_view
);

    dbg_port_type state_reg;
    dbg_port_type state_next;

    // next state of latch and direction
    always_comb begin
        state_next = state_reg;
        if (data_we) begin
            state_next.data = wdata;
        end
        if (dir_we) begin
            state_next.dir = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg.data <= DATA_RST;
            state_reg.dir  <= DIR_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // drive latch where direction is one
    assign pad.out = state_reg.data;
    assign pad.oe  = state_reg.dir & {8{drive_ok}};

    // input bits show the live pin
    generate
        for (genvar i = 0; i < 8; i++) begin : g_bit
            assign data_view[i] = state_reg.dir[i] ? state_reg.data[i]
                                                   : pin_in[i];
        end
    endgenerate
    assign dir_view = state_reg.dir;

endmodule : dbg_port_slice

// File: hdl/dbg_ports.sv
/*
 * two 8 bit bidirectional ports reached through the special register
 * area. assumes the core gives a one cycle read or write strobe with
 * address and data, which marks the read sample or write update state.
 * second port pins also carry alternate peripheral functions.
 */
`timescale 1ns/1ns
module dbg_ports
    import dbg_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // processor access
    input  wire logic [11:0] cpu_addr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_wr,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_hit,
    output logic             sra_sel,
    output logic             dba_sel,
    // system control
    input  wire logic        stop_mode,
    input  wire logic        system_output_enable,
    // first port pads
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic      [7:0]  port0_oe,
    // second port pads
    input  wire logic [7:0]  port1_in,
    output logic      [7:0]  port1_out,
    output logic      [7:0]  port1_oe,
    // alternate functions of the second port
    input  wire logic        divider_out,
    input  wire logic        divider_en,
    input  wire logic        pulse_gen_out,
    input  wire logic        pulse_gen_en,
    output logic             ext_irq_in0,
    output logic             ext_irq_in1,
    output logic             ext_irq_in2,
    output logic             timer_in1,
    output logic             timer_in2
);

    typedef struct packed {
        logic [7:0]    rdata;
        dbg_phase_type phase;
    } dbg_top_type;

    dbg_top_type   top_reg;
    dbg_top_type   top_next;
    dbg_pad_type   pad0;
    dbg_pad_type   pad1;
    logic [7:0]    view0;
    logic [7:0]    view1;
    logic [7:0]    dir0;
    logic [7:0]    dir1;
    logic          drive_ok;
    logic          p0d_sel;
    logic          p1d_sel;
    logic          p0c_sel;
    logic          p1c_sel;
    logic [7:0]    rd_mux;

    assign sra_sel = (cpu_addr >= SRA_FIRST) && (cpu_addr <= SRA_LAST);
    assign dba_sel = (cpu_addr >= DBA_FIRST) && (cpu_addr <= DBA_LAST);

    assign p0d_sel = sra_sel && (cpu_addr == PORT0_DATA_OFS);
    assign p1d_sel = sra_sel && (cpu_addr == PORT1_DATA_OFS);
    assign p0c_sel = sra_sel && (cpu_addr == PORT0_DIR_OFS);
    assign p1c_sel = sra_sel && (cpu_addr == PORT1_DIR_OFS);
    assign cpu_hit = p0d_sel | p1d_sel | p0c_sel | p1c_sel;

    // drivers released in stop without output enable
    assign drive_ok = !stop_mode || system_output_enable;

    // first port latches reset to zero
    dbg_port_slice #(
        .DATA_RST (PORT0_DATA_RST),
        .DIR_RST  (PORT0_DIR_RST)
    ) u_port0 (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .data_we   (cpu_wr && p0d_sel),
        .dir_we    (cpu_wr && p0c_sel),
        .wdata     (cpu_wdata),
        .pin_in    (port0_in),
        .drive_ok  (drive_ok),
        .pad       (pad0),
        .data_view (view0),
        .dir_view  (dir0)
    );

    // second port, latches reset to zero
    dbg_port_slice #(
        .DATA_RST (PORT1_DATA_RST),
        .DIR_RST  (PORT1_DIR_RST)
    ) u_port1 (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .data_we   (cpu_wr && p1d_sel),
        .dir_we    (cpu_wr && p1c_sel),
        .wdata     (cpu_wdata),
        .pin_in    (port1_in),
        .drive_ok  (drive_ok),
        .pad       (pad1),
        .data_view (view1),
        .dir_view  (dir1)
    );

    // read data selection
    always_comb begin
        case (1'b1)
            p0d_sel: rd_mux = view0;
            p1d_sel: rd_mux = view1;
            p0c_sel: rd_mux = dir0;
            p1c_sel: rd_mux = dir1;
            default: rd_mux = 8'h00;
        endcase
    end

    // access phase and captured read data
    always_comb begin
        top_next = top_reg;
        case (1'b1)
            cpu_rd: begin
                top_next.phase = DBG_READ_SAMPLE;
                top_next.rdata = rd_mux;
            end
            cpu_wr: begin
                top_next.phase = DBG_WRITE_UPDATE;
            end
            default: begin
                top_next.phase = DBG_IDLE;
            end
        endcase
    end

    // register the block state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            top_reg.rdata <= 8'h00;
            top_reg.phase <= DBG_IDLE;
        end else begin
            top_reg <= top_next;
        end
    end

    assign cpu_rdata = top_reg.rdata;

    // second port alternate outputs override the latch
    always_comb begin
        port1_out = pad1.out;
        if (divider_en) begin
            port1_out[P1_DIV_BIT] = divider_out;
        end
        if (pulse_gen_en) begin
            port1_out[P1_PULSE_BIT] = pulse_gen_out;
        end
    end
    assign port1_oe  = pad1.oe;
    assign port0_out = pad0.out;
    assign port0_oe  = pad0.oe;

    // alternate inputs taken from the live pins
    assign ext_irq_in0 = port1_in[P1_IRQ0_BIT];
    assign ext_irq_in1 = port1_in[P1_IRQ1_BIT];
    assign ext_irq_in2 = port1_in[P1_IRQ2_BIT];
    assign timer_in1   = port1_in[P1_TIMER1_BIT];
    assign timer_in2   = port1_in[P1_TIMER2_BIT];

endmodule : dbg_ports

// File: dv/dbg_pin_model.sv
/*
 * outside world of one port: the pin level is the device drive where
 * enabled, else the level held by the bench driver.
 */
`timescale 1ns/1ns
module dbg_pin_model (
    // device side
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    // outside driver
    input  wire logic [7:0] ext,
    output logic      [7:0] pin
);
    always_comb pin = (oe & out) | (~oe & ext);
endmodule : dbg_pin_model

// File: dv/dbg_ports_assertions.sv
/*
 * checker for the dual byte port block, bound to its top ports.
 * assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ns
module dbg_ports_checker
    import dbg_pkg::*;
(
    // watched ports
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [11:0] cpu_addr,
    input wire logic        cpu_rd,
    input wire logic        cpu_wr,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        cpu_hit,
    input wire logic        sra_sel,
    input wire logic        dba_sel,
    input wire logic        stop_mode,
    input wire logic        system_output_enable,
    input wire logic [7:0]  port0_in,
    input wire logic [7:0]  port0_out,
    input wire logic [7:0]  port0_oe,
    input wire logic [7:0]  port1_in,
    input wire logic [7:0]  port1_oe,
    input wire logic        ext_irq_in2,
    input wire logic        timer_in2
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence wr_at(logic [11:0] a);
        cpu_wr && !cpu_rd && cpu_addr == a;
    endsequence
    rst_clear_a: assert property (disable iff (1'b0)
        sys_rst |=> port0_out == 8'h00 && port0_oe == 8'h00
        && port1_oe == 8'h00) else $error("reset state wrong");
    dir0_write_a: assert property (
        wr_at(PORT0_DIR_OFS) ##0 !stop_mode |=>
        stop_mode || port0_oe == $past(cpu_wdata))
        else $error("port0 enable missed write");
    dir1_write_a: assert property (
        wr_at(PORT1_DIR_OFS) ##0 !stop_mode |=>
        stop_mode || port1_oe == $past(cpu_wdata))
        else $error("port1 enable missed write");
    data0_write_a: assert property (
        wr_at(PORT0_DATA_OFS) |=> port0_out == $past(cpu_wdata))
        else $error("port0 latch missed write");
    read_mix_a: assert property (
        cpu_rd && cpu_addr == PORT0_DATA_OFS && !stop_mode |=>
        cpu_rdata == $past((port0_oe & port0_out) | (~port0_oe & port0_in)))
        else $error("port0 read value wrong");
    unmapped_read_a: assert property (
        cpu_rd && !cpu_hit |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    area_decode_a: assert property (
        sra_sel == (cpu_addr <= SRA_LAST) && dba_sel == (cpu_addr >= DBA_FIRST))
        else $error("area decode wrong");
    alt_inputs_a: assert property (
        ext_irq_in2 == port1_in[2] && timer_in2 == port1_in[5])
        else $error("alternate input wrong");
    stop_release_a: assert property (
        stop_mode && !system_output_enable |-> port0_oe == 8'h00
        && port1_oe == 8'h00) else $error("stop drive not released");
    cover property (cpu_rd && cpu_hit);
    cover property (wr_at(PORT0_DIR_OFS));
    cover property (stop_mode && !system_output_enable);
endmodule : dbg_ports_checker

bind dbg_ports dbg_ports_checker i_chk (.ref_clk, .sys_rst, .cpu_addr,
    .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_hit, .sra_sel,
    .dba_sel, .stop_mode, .system_output_enable, .port0_in, .port0_out,
    .port0_oe, .port1_in, .port1_oe, .ext_irq_in2, .timer_in2);

// File: dv/dbg_ports_tb_top.sv
/*
 * testbench for the dual byte port block: register tasks, pin models.
 * assumes the one cycle strobe access of the block.
 */
`timescale 1ns/1ns
module dbg_ports_tb_top;
    import dbg_pkg::*;
    logic        ref_clk, sys_rst, cpu_rd, cpu_wr, cpu_hit, sra_sel, dba_sel;
    logic        stop_mode, oen, dv, dve, pg, pge;
    logic [11:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, p0i, p0o, p0e, p1i, p1o, p1e, x0, x1;
    logic [4:0]  alt;
    int          fails, n_compared, cyc;
    // address decode probes and expected {hit, sra, dba}
    logic [11:0] dec_a [4] = '{12'h009, 12'h03F, 12'h040, 12'hF90};
    logic [7:0]  dec_e [4] = '{8'h06, 8'h02, 8'h00, 8'h01};
    dbg_ports i_dbg_ports (.ref_clk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr,
        .cpu_wdata, .cpu_rdata, .cpu_hit, .sra_sel, .dba_sel, .stop_mode,
        .system_output_enable(oen), .port0_in(p0i), .port0_out(p0o),
        .port0_oe(p0e), .port1_in(p1i), .port1_out(p1o), .port1_oe(p1e),
        .divider_out(dv), .divider_en(dve), .pulse_gen_out(pg),
        .pulse_gen_en(pge), .ext_irq_in0(alt[4]), .ext_irq_in1(alt[3]),
        .ext_irq_in2(alt[2]), .timer_in1(alt[1]), .timer_in2(alt[0]));
    dbg_pin_model i_pin0 (.out(p0o), .oe(p0e), .ext(x0), .pin(p0i));
    dbg_pin_model i_pin1 (.out(p1o), .oe(p1e), .ext(x1), .pin(p1i));
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one strobe per call; strobe stays up until the next call or idle
    task automatic acc(input logic r, input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(negedge ref_clk);
        cpu_rd = r;
        cpu_wr = w;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge ref_clk);
        #1;
    endtask : acc
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        acc(1'b1, 1'b0, a, 8'h00);
        chk(cpu_rdata, e);
    endtask : rd
    task automatic idle;
        acc(1'b0, 1'b0, cpu_addr, 8'h00);
    endtask : idle
    // main sequence
    initial begin
        {cpu_rd, cpu_wr, stop_mode, dv, dve, pg, pge} = '0;
        {cpu_addr, cpu_wdata, oen, x0, x1} = {12'h000, 8'h00, 1'b1, 8'h3C, 8'hA5};
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk(p0o, 8'h00);
        chk(p1o, 8'h00);
        rd(PORT0_DIR_OFS, 8'h00);
        rd(PORT1_DIR_OFS, 8'h00);
        rd(PORT0_DATA_OFS, 8'h3C);
        // whole byte writes only, never read modify write
        acc(1'b0, 1'b1, PORT0_DATA_OFS, 8'hA5);
        acc(1'b0, 1'b1, PORT0_DIR_OFS, 8'hF0);
        idle();
        chk(p0o, 8'hA5);
        chk(p0e, 8'hF0);
        rd(PORT0_DATA_OFS, 8'hAC);
        // pin level changed off the edge, held until read
        @(negedge ref_clk);
        x0 = 8'hC3;
        rd(PORT0_DATA_OFS, 8'hA3);
        acc(1'b0, 1'b1, PORT1_DATA_OFS, 8'h18);
        acc(1'b0, 1'b1, PORT1_DIR_OFS, 8'h18);
        @(negedge ref_clk);
        {dve, pge, dv, pg} = 4'b1101;
        idle();
        chk(p1o & 8'h18, 8'h10);
        chk({3'b000, alt}, 8'h17);
        rd(PORT1_DATA_OFS, 8'hBD);
        // unmapped cell 002 written and read, then decode probes, mapped 009 among them
        acc(1'b0, 1'b1, 12'h002, 8'hFF);
        rd(12'h002, 8'h00);
        foreach (dec_a[i]) begin
            acc(1'b0, 1'b0, dec_a[i], 8'h00);
            chk({5'b00000, cpu_hit, sra_sel, dba_sel}, dec_e[i]);
        end
        @(negedge ref_clk);
        {stop_mode, oen} = 2'b10;
        idle();
        chk(p0e, 8'h00);
        @(negedge ref_clk);
        oen = 1'b1;
        idle();
        chk(p0e, 8'hF0);
        end_of_test();
    end
endmodule : dbg_ports_tb_top
